/* verilog/bfhrc_top.sv */
// Bus cycle termination, fault exception, halt and reset control
`timescale 1ns/1ps
`default_nettype none
`include "bfhrc_defs.svh"

module bfhrc_top
   import bfhrc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Bus pins
   input  wire logic        transfer_ack_n_i,
   input  wire logic        bus_fault_in_n_i,
   input  wire logic        stop_req_n_i,
   input  wire logic        reset_n_i,
   output logic             reset_n_o,
   output logic             reset_oe_o,
   input  wire logic [15:0] data_i,
   output logic [15:0]      data_o,
   output logic             data_oe_o,
   output logic [23:0]      addr_o,
   output logic             addr_oe_o,
   output logic [2:0]       fc_o,
   output logic             rw_n_o,
   output logic             cycle_strobe_n_o,
   output logic             ctrl_oe_o,
   // Arbitration unit
   input  wire logic        arb_release_i,
   // Core side
   input  wire logic        cyc_req_i,
   input  wire logic        cyc_write_i,
   input  wire logic        cyc_rmw_i,
   input  wire logic [23:0] cyc_addr_i,
   input  wire logic [15:0] cyc_wdata_i,
   input  wire logic [2:0]  cyc_fc_i,
   output logic             cyc_done_o,
   output logic             cyc_abort_o,
   output logic [15:0]      cyc_rdata_o,
   input  wire logic [31:0] pc_i,
   input  wire logic [15:0] sr_i,
   input  wire logic        instr_start_i,
   input  wire logic        reset_instr_i,
   output logic [31:0]      new_pc_o,
   output logic             new_pc_ld_o,
   output logic [31:0]      ssp_o,
   output logic             ipl_set_o,
   output logic [2:0]       ipl_val_o,
   output logic             dbl_halt_o,
   output logic             stopped_o
);

   bfhrc_core_s r;
   bfhrc_core_s n;
   bfhrc_rst_if rif ();

   // ----------------------------------------------------------------
   // Reset line controller
   // ----------------------------------------------------------------
   bfhrc_rst_ctl u_rst (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .p      (rif.ctl)
   );

   assign rif.pin_s  = r.rpin_s;
   assign rif.stop_s = r.stop_s;
   assign rif.instr  = reset_instr_i;

   // Ending state: a fault without acknowledge first seen after S2 runs to S9
   function automatic logic [3:0] end_of(input logic flt, input logic ack, input logic early);
      logic [3:0] e;
      e = (flt && !ack && !early) ? `BFHRC_BST_END_FLT : `BFHRC_BST_END_OK;
      return e;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [3:0]  end_r;
      logic [3:0]  end_n;
      logic [31:0] sp_dec;
      end_r  = end_of(r.flt_seen, r.ack_seen, r.flt_early);
      end_n  = 4'h0;
      sp_dec = r.supervisor_stack_pointer - `BFHRC_SP_STEP;
      n = r;
      // Two flops on the fault, acknowledge, stop and reset pins before use
      n.fault_m = ~bus_fault_in_n_i;
      n.fault_s = r.fault_m;
      n.ack_m   = ~transfer_ack_n_i;
      n.ack_s   = r.ack_m;
      n.stop_m  = ~stop_req_n_i;
      n.stop_s  = r.stop_m;
      n.rpin_m  = ~reset_n_i;
      n.rpin_s  = r.rpin_m;
      n.done    = 1'b0;
      n.abort   = 1'b0;
      n.vec_ld  = 1'b0;
      n.ipl7    = 1'b0;
      // Instruction boundary closes the double fault window; a new fault wins
      if (instr_start_i && r.seq == SQ_NONE) begin
         n.exc_open = 1'b0;
      end
      if (rif.ext_hold) begin
         n.st      = ST_RST_HOLD;
         n.strobe  = 1'b0;
         n.addr_oe = 1'b0;
         n.data_oe = 1'b0;
      end else begin
         case (r.st)
            ST_RST_HOLD: begin
               // Reset released: fetch vectors, window open until first instruction
               n.seq      = SQ_RST;
               n.step     = 3'h0;
               n.exc_open = 1'b1;
               n.ipl7     = 1'b1;
               n.st       = ST_IDLE;
            end
            ST_IDLE: begin
               // No cycle starts while stop is seen; buses stay floating
               if (!r.stop_s && !arb_release_i && (r.seq != SQ_NONE || cyc_req_i)) begin
                  n.st        = ST_CYC;
                  n.bst       = 4'h0;
                  n.flt_seen  = 1'b0;
                  n.flt_early = 1'b0;
                  n.ack_seen  = 1'b0;
                  n.addr_oe   = 1'b1;
                  n.c_fc      = `BFHRC_FC_SUP_DATA;
                  n.c_rmw     = 1'b0;
                  n.c_core    = 1'b0;
                  n.c_wdata   = 16'h0000;
                  if (r.seq == SQ_EXC && r.step <= `BFHRC_EXC_LAST_PUSH) begin
                     // Push PC, status, then error information
                     n.c_wr   = 1'b1;
                     n.supervisor_stack_pointer    = sp_dec;
                     n.c_addr = sp_dec[23:0];
                     case (r.step)
                        3'h0:    n.c_wdata = pc_i[15:0];
                        3'h1:    n.c_wdata = pc_i[31:16];
                        3'h2:    n.c_wdata = sr_i;
                        3'h3:    n.c_wdata = r.err_addr[15:0];
                        3'h4:    n.c_wdata = {8'h00, r.err_addr[23:16]};
                        default: n.c_wdata = r.err_stat;
                     endcase
                  end else if (r.seq == SQ_EXC) begin
                     // Fault vector, high word first
                     n.c_wr   = 1'b0;
                     n.c_addr = `BFHRC_VEC_FAULT + {22'h000000, r.step[0], 1'b0};
                  end else if (r.seq == SQ_RST) begin
                     n.c_wr   = 1'b0;
                     n.c_addr = (r.step[1] ? `BFHRC_VEC_PC : `BFHRC_VEC_SSP)
                                + {22'h000000, r.step[0], 1'b0};
                  end else begin
                     n.c_wr    = cyc_write_i;
                     n.c_addr  = cyc_addr_i;
                     n.c_wdata = cyc_wdata_i;
                     n.c_fc    = cyc_fc_i;
                     n.c_rmw   = cyc_rmw_i;
                     n.c_core  = 1'b1;
                  end
                  n.data_oe = n.c_wr;
               end
            end
            ST_CYC: begin
               if (r.bst == end_r) begin
                  n.strobe  = 1'b0;
                  n.addr_oe = 1'b0;
                  n.data_oe = 1'b0;
                  if (r.flt_seen && r.stop_s && !r.c_rmw) begin
                     // Re-run: keep the latched cycle, no exception counted
                     n.st = ST_RR_WAIT;
                  end else if (r.flt_seen) begin
                     n.abort = r.c_core;
                     if (r.exc_open) begin
                        n.st  = ST_DBL;
                        n.seq = SQ_NONE;
                     end else begin
                        n.exc_open = 1'b1;
                        n.err_addr = r.c_addr;
                        n.err_stat = {11'h000, r.c_rmw, ~r.c_wr, r.c_fc};
                        n.seq      = SQ_EXC;
                        n.step     = 3'h0;
                        n.st       = ST_FLT_WAIT;
                     end
                  end else begin
                     // Normal ending; halt follows in idle if stop is seen
                     n.st = ST_IDLE;
                     if (r.seq == SQ_RST) begin
                        if (r.step[1]) begin
                           n.pc_new = r.step[0] ? {r.pc_new[31:16], r.rdata} : {r.rdata, r.pc_new[15:0]};
                        end else begin
                           n.supervisor_stack_pointer = r.step[0] ? {r.supervisor_stack_pointer[31:16], r.rdata} : {r.rdata, r.supervisor_stack_pointer[15:0]};
                        end
                        n.step = r.step + 3'h1;
                        if (r.step == `BFHRC_RST_LAST) begin
                           n.seq    = SQ_NONE;
                           n.vec_ld = 1'b1;
                        end
                     end else if (r.seq == SQ_EXC) begin
                        if (r.step > `BFHRC_EXC_LAST_PUSH) begin
                           n.pc_new = r.step[0] ? {r.pc_new[31:16], r.rdata} : {r.rdata, r.pc_new[15:0]};
                        end
                        n.step = r.step + 3'h1;
                        if (r.step == `BFHRC_EXC_VEC_LO) begin
                           n.seq    = SQ_NONE;
                           n.vec_ld = 1'b1;
                        end
                     end else begin
                        n.done = 1'b1;
                     end
                  end
               end else begin
                  // Fault sampled from S2 on; early fault keeps the S7 ending
                  if (r.bst >= `BFHRC_BST_STROBE && r.fault_s) begin
                     n.flt_seen = 1'b1;
                     if (r.bst == `BFHRC_BST_STROBE) begin
                        n.flt_early = 1'b1;
                     end
                  end
                  if (r.bst == `BFHRC_BST_ACK && r.ack_s) begin
                     n.ack_seen = 1'b1;
                  end
                  if (r.bst == `BFHRC_BST_DATA && !r.c_wr) begin
                     n.rdata = data_i;
                  end
                  // Wait states in S4 until acknowledge or fault
                  if (r.bst == `BFHRC_BST_ACK && !n.ack_seen && !n.flt_seen) begin
                     n.bst = r.bst;
                  end else begin
                     n.bst = r.bst + 4'h1;
                  end
                  end_n    = end_of(n.flt_seen, n.ack_seen, n.flt_early);
                  n.strobe = (n.bst >= `BFHRC_BST_STROBE) && (n.bst < end_n);
               end
            end
            ST_FLT_WAIT: begin
               // Buses float until the fault input is negated
               if (!r.fault_s) begin
                  n.st = ST_IDLE;
               end
            end
            ST_RR_WAIT: begin
               // Same address, codes, controls and write data again
               if (!r.stop_s && !arb_release_i) begin
                  n.st        = ST_CYC;
                  n.bst       = 4'h0;
                  n.flt_seen  = 1'b0;
                  n.flt_early = 1'b0;
                  n.ack_seen  = 1'b0;
                  n.addr_oe   = 1'b1;
                  n.data_oe   = r.c_wr;
               end
            end
            ST_DBL: begin
               // Only an external reset leaves this state
               n.st = ST_DBL;
            end
            default: begin
               n.st = ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register; reset leads into the vector fetch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         r    <= '0;
         r.st <= ST_RST_HOLD;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Arbitration alone takes the control signals off the bus
   assign ctrl_oe_o        = ~arb_release_i;
   assign addr_oe_o        = r.addr_oe & ~arb_release_i;
   assign data_oe_o        = r.data_oe & ~arb_release_i;
   assign addr_o           = r.c_addr;
   assign data_o           = r.c_wdata;
   assign fc_o             = r.c_fc;
   assign rw_n_o           = ~r.c_wr;
   assign cycle_strobe_n_o = ~r.strobe;
   assign reset_n_o        = 1'b0;                 // Line is only ever pulled low
   assign reset_oe_o       = rif.drive;
   assign cyc_done_o       = r.done;
   assign cyc_abort_o      = r.abort;
   assign cyc_rdata_o      = r.rdata;
   assign new_pc_o         = r.pc_new;
   assign new_pc_ld_o      = r.vec_ld;
   assign ssp_o            = r.supervisor_stack_pointer;
   assign ipl_set_o        = r.ipl7;
   assign ipl_val_o        = `BFHRC_IPL_RESET;
   assign dbl_halt_o       = (r.st == ST_DBL);
   assign stopped_o        = r.stop_s & (r.st == ST_IDLE || r.st == ST_RR_WAIT);

endmodule

`default_nettype wire

/* verilog/bfhrc_defs.svh */
// Constants for the bus fault, halt and reset control block
//
// Contract
// - A bus fault ends the current cycle; an early fault drops the strobe in S7.
// - Buses float while the fault input stays asserted; stacking starts after it drops.
// - Exception order: push PC and status, push error info, fetch vector, run handler.
// - The new program counter comes from the fault vector at byte address 000008.
// - Fault with stop request held: end cycle, float buses, wait for stop release.
// - After stop release repeat the faulted cycle with the same codes, controls and data.
// - A read-modify-write cycle is never repeated; fault plus stop gives an exception.
// - Stop request held active means no activity; held inactive means normal running.
// - Single step: stop released until a cycle starts, then one cycle per step.
// - A cycle finished under an active stop request leaves address and data floating.
// - Arbitration keeps working while stopped; it alone releases the control signals.
// - A second fault exception before the next instruction is a double fault; halt.
// - Repeated cycles never count toward a double fault; repeats are unlimited.
// - A fault during reset vector fetch or before the first instruction halts.
// - External reset loads the stack pointer from 000000, then the PC from 000004.
// - External reset sets the interrupt mask to seven and, apart from the stack pointer and PC vector loads, touches nothing else.
// - The reset instruction drives the reset line for 124 clocks; registers unaffected.
// - Stop with or before acknowledge halts after the cycle; fault gives fault ending.
// - Fault sampled every edge from S2; without acknowledge a fault first seen after S2 ends the cycle in S9.
`ifndef BFHRC_DEFS_SVH
`define BFHRC_DEFS_SVH

// ----------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------
`define BFHRC_VEC_SSP        24'h000000
`define BFHRC_VEC_PC         24'h000004
`define BFHRC_VEC_FAULT      24'h000008
`define BFHRC_WORD_STEP      24'h000002
`define BFHRC_SP_STEP        32'h00000002

// ----------------------------------------------------------------
// Bus state numbers, one clock each
// ----------------------------------------------------------------
`define BFHRC_BST_STROBE     4'h2
`define BFHRC_BST_ACK        4'h4
`define BFHRC_BST_DATA       4'h6
`define BFHRC_BST_END_OK     4'h7
`define BFHRC_BST_END_FLT    4'h9

// ----------------------------------------------------------------
// Sequencer steps and codes
// ----------------------------------------------------------------
`define BFHRC_EXC_LAST_PUSH  3'h5
`define BFHRC_EXC_VEC_LO     3'h7
`define BFHRC_RST_LAST       3'h3
`define BFHRC_FC_SUP_DATA    3'h5
`define BFHRC_IPL_RESET      3'h7

// ----------------------------------------------------------------
// Reset timing in clock periods
// ----------------------------------------------------------------
`define BFHRC_RST_DRIVE_CLKS 7'h7C
`define BFHRC_EXT_RST_CLKS   4'hA

`endif

/* verilog/bfhrc_pkg.sv */
// Types shared by the bus fault, halt and reset control block
package bfhrc_pkg;

   // Main controller states
   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_CYC      = 3'h1,
      ST_FLT_WAIT = 3'h2,
      ST_RR_WAIT  = 3'h3,
      ST_DBL      = 3'h4,
      ST_RST_HOLD = 3'h5
   } bfhrc_state_e;

   // Internal cycle sequences
   typedef enum logic [1:0] {
      SQ_NONE = 2'h0,
      SQ_EXC  = 2'h1,
      SQ_RST  = 2'h2
   } bfhrc_seq_e;

   // Whole state of the main controller
   typedef struct packed {
      logic         fault_m;
      logic         fault_s;
      logic         ack_m;
      logic         ack_s;
      logic         stop_m;
      logic         stop_s;
      logic         rpin_m;
      logic         rpin_s;
      bfhrc_state_e st;
      logic [3:0]   bst;
      logic         flt_early;
      logic         flt_seen;
      logic         ack_seen;
      logic [23:0]  c_addr;
      logic [15:0]  c_wdata;
      logic [2:0]   c_fc;
      logic         c_wr;
      logic         c_rmw;
      logic         c_core;
      logic [23:0]  err_addr;
      logic [15:0]  err_stat;
      bfhrc_seq_e   seq;
      logic [2:0]   step;
      logic [31:0]  supervisor_stack_pointer;
      logic [31:0]  pc_new;
      logic [15:0]  rdata;
      logic         exc_open;
      logic         done;
      logic         abort;
      logic         vec_ld;
      logic         ipl7;
      logic         strobe;
      logic         addr_oe;
      logic         data_oe;
   } bfhrc_core_s;

   // Whole state of the reset line controller
   typedef struct packed {
      logic [6:0] cnt;
      logic       drive;
      logic [3:0] hcnt;
      logic       ext_hold;
   } bfhrc_rc_s;

endpackage

/* verilog/bfhrc_rst_if.sv */
// Link between the main controller and the reset line controller
`timescale 1ns/1ps
`default_nettype none

interface bfhrc_rst_if;
   logic pin_s;     // Reset line seen low, synchronised
   logic stop_s;    // Stop request seen active, synchronised
   logic instr;     // Reset instruction pulse
   logic drive;     // We are driving the reset line
   logic ext_hold;  // External reset recognised and still held

   modport ctl (input pin_s, input stop_s, input instr, output drive, output ext_hold);
   modport top (output pin_s, output stop_s, output instr, input drive, input ext_hold);
endinterface

`default_nettype wire

/* verilog/bfhrc_rst_ctl.sv */
// Reset line controller: reset instruction pulse and external reset detection
`timescale 1ns/1ps
`default_nettype none

module bfhrc_rst_ctl
   import bfhrc_pkg::*;
(
   input  wire logic   clk_i,
   input  wire logic   rstn_i,
   bfhrc_rst_if.ctl    p
);

   bfhrc_rc_s r;
   bfhrc_rc_s n;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      n = r;
      // Drive the line a fixed count; core registers are not touched here
      if (p.instr && !r.drive && !r.ext_hold) begin
         n.drive = 1'b1;
         n.cnt   = `BFHRC_RST_DRIVE_CLKS;
      end else if (r.drive) begin
         if (r.cnt == 7'h01) begin
            n.drive = 1'b0;
         end
         n.cnt = r.cnt - 7'h01;
      end
      // Our own drive is ignored so a reset instruction never resets us
      if (!r.drive && p.pin_s && p.stop_s) begin
         if (r.hcnt == `BFHRC_EXT_RST_CLKS - 4'h1) begin
            n.ext_hold = 1'b1;
         end else begin
            n.hcnt = r.hcnt + 4'h1;
         end
      end else begin
         n.hcnt     = 4'h0;
         n.ext_hold = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign p.drive    = r.drive;
   assign p.ext_hold = r.ext_hold;

endmodule

`default_nettype wire

/* tb/bfhrc_top_assertions.sv */
// Checker of fault, halt and reset behaviour seen at the block pins
`timescale 1ns/1ps
`default_nettype none

module bfhrc_chk (
   input wire logic       clk_i,
   input wire logic       rstn_i,
   input wire logic       bus_fault_in_n_i,
   input wire logic       stop_req_n_i,
   input wire logic       arb_release_i,
   input wire logic       reset_oe_o,
   input wire logic       addr_oe_o,
   input wire logic       data_oe_o,
   input wire logic       cycle_strobe_n_o,
   input wire logic       ctrl_oe_o,
   input wire logic       ipl_set_o,
   input wire logic [2:0] ipl_val_o,
   input wire logic       dbl_halt_o,
   input wire logic       stopped_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Length of the current reset line drive
   logic [7:0] run_r;
   always_ff @(posedge clk_i) begin
      if (!rstn_i || !reset_oe_o) run_r <= 8'h00;
      else run_r <= run_r + 8'h01;
   end

   // Pins lag two clocks through the synchronisers, hence three held cycles
   sequence s_cyc_open;
      $fell(cycle_strobe_n_o);
   endsequence
   sequence s_fault_held;
      (!cycle_strobe_n_o && !bus_fault_in_n_i)[*3];
   endsequence

   a_drive_exact: assert property ($fell(reset_oe_o) |-> run_r == 8'h7C)
      else $error("reset drive length wrong");
   a_drive_bound: assert property (reset_oe_o |-> run_r < 8'h7C)
      else $error("reset drive too long");
   a_strobe_min: assert property (s_cyc_open |-> !cycle_strobe_n_o[*5])
      else $error("strobe ended before S7");
   a_fault_ends: assert property (s_fault_held |-> ##[0:6] cycle_strobe_n_o)
      else $error("fault did not end cycle by S9");
   a_fault_float: assert property ((!bus_fault_in_n_i && cycle_strobe_n_o)[*2] |-> !addr_oe_o && !data_oe_o)
      else $error("buses driven while fault held");
   a_stop_idle: assert property (!stop_req_n_i[*4] |-> !$rose(addr_oe_o))
      else $error("cycle started under stop");
   a_stop_float: assert property (stopped_o |-> !addr_oe_o && !data_oe_o)
      else $error("buses driven while stopped");
   a_arb_owns: assert property (arb_release_i |-> !ctrl_oe_o && !addr_oe_o && !data_oe_o)
      else $error("pins driven while bus given away");
   a_dbl_quiet: assert property ($past(dbl_halt_o, 8) && dbl_halt_o |-> cycle_strobe_n_o && !addr_oe_o)
      else $error("activity in double fault halt");
   a_mask_seven: assert property ($rose(rstn_i) |-> ##[1:2] (ipl_set_o && ipl_val_o == 3'h7))
      else $error("mask not set to seven");
endmodule

bind bfhrc_top bfhrc_chk u_chk (.clk_i, .rstn_i, .bus_fault_in_n_i, .stop_req_n_i, .arb_release_i, .reset_oe_o,
   .addr_oe_o, .data_oe_o, .cycle_strobe_n_o, .ctrl_oe_o, .ipl_set_o, .ipl_val_o, .dbl_halt_o, .stopped_o);

`default_nettype wire

/* tb/bfhrc_slave.sv */
// Model of the external slave and watchdog that end bus cycles
`timescale 1ns/1ps
`default_nettype none

module bfhrc_slave (
   input wire logic        clk_i,
   input wire logic        strobe_n_i,
   input wire logic        rw_n_i,
   input wire logic [23:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        flt_i,
   input wire logic [3:0]  dly_i,
   output logic            ack_n_o,
   output logic            fault_n_o,
   output logic [15:0]     rdata_o
);
   logic [23:0] log_a [64];
   logic [15:0] log_d [64];
   logic        log_w [64];
   int          n = 0;
   logic [3:0]  cnt_r = 4'h0;
   logic [1:0]  hold_r = 2'h0;
   logic [15:0] word_r = 16'h0000;
   logic        drv_r = 1'b0;

   // Released data lines show the inverse, so stale data never matches
   assign rdata_o = drv_r ? word_r : ~word_r;

   initial {ack_n_o, fault_n_o} = 2'b11;
   // Pins move on rising edges; fault held past the strobe
   always @(posedge clk_i) begin
      if (strobe_n_i) begin
         cnt_r <= 4'h0;
         ack_n_o <= 1'b1;
         drv_r <= 1'b0;
         if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
         else fault_n_o <= 1'b1;
      end else begin
         if (cnt_r == 4'h0) begin
            log_a[n] <= addr_i;
            log_d[n] <= wdata_i;
            log_w[n] <= !rw_n_i;
            n <= n + 1;
         end
         cnt_r <= cnt_r + 4'h1;
         if (cnt_r == dly_i && flt_i) begin
            fault_n_o <= 1'b0;
            hold_r <= 2'h3;
         end else if (cnt_r == dly_i) begin
            ack_n_o <= 1'b0;
            drv_r <= rw_n_i;
            word_r <= addr_i[15:0] ^ 16'h5A5A;
         end
      end
   end
endmodule

`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the fault, halt and reset control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("FAIL %0t got %0h exp %0h", $time, a, e); end end
`define WT(c) begin int t; t = 0; while (!(c) && t < 400) begin @(negedge clk_i); t++; end `CHK(c, 1'b1) end
`define PLS(s) begin @(negedge clk_i); s = 1'b1; @(negedge clk_i); s = 1'b0; end

module tb;
   localparam logic [31:0] SSP0 = 32'h5A5A5A58;
   logic        clk_i = 1'b0, rstn_i = 1'b0, ext_n = 1'b1, stop_req_n_i = 1'b1, arb_release_i = 1'b0;
   logic        cyc_req_i = 1'b0, cyc_write_i = 1'b0, instr_start_i = 1'b0, reset_instr_i = 1'b0;
   logic        cyc_rmw_i = 1'b0, flt = 1'b0, w;
   logic [2:0]  cyc_fc_i = 3'h1, fc_o, ipl_val_o;
   logic [3:0]  dly = 4'h0;
   logic [23:0] cyc_addr_i = 24'h000000, a, addr_o;
   logic [15:0] cyc_wdata_i = 16'h0000, sr_i = 16'h2700, d, data_i, data_o, cyc_rdata_o;
   logic [31:0] pc_i = 32'h00001000, new_pc_o, ssp_o;
   logic        transfer_ack_n_i, bus_fault_in_n_i, reset_n_o, reset_oe_o, data_oe_o, addr_oe_o, rw_n_o;
   logic        cycle_strobe_n_o, ctrl_oe_o, cyc_done_o, cyc_abort_o, new_pc_ld_o, ipl_set_o, dbl_halt_o, stopped_o;
   wire         reset_n_i;
   int          error_cnt = 0, n_checks = 0, clk_cnt = 0, k0;
   logic [40:0] rows [4] = '{{1'b0, 24'h000100, 16'h0000}, {1'b1, 24'h000102, 16'hA55A},
                             {1'b0, 24'hFFFFFE, 16'h0000}, {1'b1, 24'h800000, 16'h1234}};

   // Reset line has a pull-up; either party may pull it low
   assign reset_n_i = ext_n & ~(reset_oe_o & ~reset_n_o);
   always #50 clk_i = ~clk_i;

   bfhrc_top uut (.*);
   bfhrc_slave u_slv (.clk_i, .strobe_n_i(cycle_strobe_n_o), .rw_n_i(rw_n_o), .addr_i(addr_o),
      .wdata_i(data_o), .flt_i(flt), .dly_i(dly), .ack_n_o(transfer_ack_n_i),
      .fault_n_o(bus_fault_in_n_i), .rdata_o(data_i));

   function automatic logic [15:0] wd(input logic [23:0] x);
      return x[15:0] ^ 16'h5A5A;
   endfunction

   task close_out;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Request held until the cycle ends either way
   task cyc(input logic cw, input logic [23:0] ca, input logic [15:0] cd);
      @(negedge clk_i);
      {cyc_req_i, cyc_write_i, cyc_addr_i, cyc_wdata_i} = {1'b1, cw, ca, cd};
      `WT(cyc_done_o | cyc_abort_o)
      cyc_req_i = 1'b0;
   endtask

   // Reset and stop held together ten clocks and more
   task ext_reset;
      {ext_n, stop_req_n_i} = 2'b00;
      repeat (12) @(negedge clk_i);
      {ext_n, stop_req_n_i} = 2'b11;
   endtask

   // Hang guard, far past the expected run length
   always @(posedge clk_i) begin
      clk_cnt++;
      if (clk_cnt == 6000) begin
         error_cnt++;
         close_out;
      end
   end

   initial begin
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1;
      `WT(new_pc_ld_o)
      `CHK(u_slv.log_a[0], 24'h000000)
      `CHK(ssp_o, SSP0)
      `CHK(new_pc_o, {wd(24'h4), wd(24'h6)})
      `PLS(instr_start_i)
      for (int i = 0; i < 4; i++) begin
         {w, a, d} = rows[i];
         dly = i[3:0];
         cyc(w, a, d);
         `CHK(cyc_done_o, 1'b1)
         `CHK(u_slv.log_a[u_slv.n - 1], a)
         if (w) `CHK(u_slv.log_d[u_slv.n - 1], d)
         else `CHK(cyc_rdata_o, wd(a))
      end
      {stop_req_n_i, arb_release_i} = 2'b01;
      repeat (6) @(negedge clk_i);
      `CHK(stopped_o, 1'b1)
      `CHK(ctrl_oe_o, 1'b0)
      arb_release_i = 1'b0;
      k0 = u_slv.n;
      fork
         cyc(1'b0, 24'h000200, 16'h0000);
         begin
            repeat (20) @(negedge clk_i);
            `CHK(u_slv.n, k0)
            stop_req_n_i = 1'b1;
         end
      join
      `PLS(reset_instr_i)
      repeat (2) @(negedge clk_i);
      `CHK(reset_n_i, 1'b0)
      repeat (126) @(negedge clk_i);
      `CHK(reset_oe_o, 1'b0)
      `CHK(ssp_o, SSP0)
      {flt, dly} = {1'b1, 4'h2};
      cyc(1'b0, 24'h003000, 16'h0000);
      `CHK(cyc_abort_o, 1'b1)
      flt = 1'b0;
      `WT(new_pc_ld_o)
      `CHK(new_pc_o, {wd(24'h8), wd(24'hA)})
      `CHK(u_slv.log_a[u_slv.n - 2], 24'h000008)
      `CHK(u_slv.log_w[u_slv.n - 3], 1'b1)
      `CHK(ssp_o, SSP0 - 32'h0000000C)
      // Re-run while the double fault window is still open
      {k0, dly} = {u_slv.n, 4'h1};
      fork
         cyc(1'b1, 24'h004000, 16'hBEEF);
         begin
            `WT(!cycle_strobe_n_o)
            {stop_req_n_i, flt} = 2'b01;
            repeat (16) @(negedge clk_i);
            `CHK(addr_oe_o, 1'b0)
            {stop_req_n_i, flt} = 2'b10;
         end
      join
      `CHK(cyc_done_o, 1'b1)
      `CHK(u_slv.n, k0 + 2)
      `CHK(u_slv.log_d[k0 + 1], 16'hBEEF)
      `CHK({fc_o, u_slv.log_a[k0 + 1]}, {3'h1, 24'h004000})
      {flt, cyc_rmw_i} = 2'b11;
      fork
         cyc(1'b0, 24'h005000, 16'h0000);
         begin
            `WT(!cycle_strobe_n_o)
            stop_req_n_i = 1'b0;
         end
      join
      `WT(dbl_halt_o)
      flt = 1'b0;
      ext_reset;
      `WT(new_pc_ld_o)
      `CHK(dbl_halt_o, 1'b0)
      flt = 1'b1;
      ext_reset;
      `WT(dbl_halt_o)
      close_out;
   end
endmodule

`default_nettype wire
